//--- rtl/oitr_regs.sv
// Serial configuration port, trim and over-range registers, SDO mux
`timescale 1ns/1ps
module oitr_regs
  import oitr_pkg::*;
#(
  parameter int OVR_LATENCY = LATENCY_DEF
) (
  input  wire logic           clk,
  input  wire logic           arst_n,
  input  wire oitr_spi_pins_t spi_pins,
  input  wire oitr_sample_t   sample,
  output logic                sdo,
  output logic                sdo_oe,
  output logic [AMP_W-1:0]    amplitude_trim_code,
  output logic [PH_W-1:0]     phase_trim_code,
  output logic                overrange_indicator
);

  // ************************************************************
  // Types and state
  // ************************************************************
  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } oitr_spi_state_t;

  typedef struct packed {
    oitr_spi_pins_t    sync1;
    oitr_spi_pins_t    sync2;
    logic              sclk_prev;
    oitr_spi_state_t   st;
    logic [BCNT_W-1:0] bitcnt;
    logic [FRAME_BITS-1:0] shreg;
    logic [DATA_W-1:0] outsh;
    logic              rd_phase;
    logic              sdo;
    logic              sdo_oe;
    logic              ovr_out;
    logic [DATA_W-1:0] imbalance_trim;
    logic [DATA_W-1:0] overrange_enable_ctrl;
    logic [DATA_W-1:0] overrange_hold_ctrl;
    logic [DATA_W-1:0] overrange_threshold_level;
  } oitr_state_t;

  oitr_state_t state_reg;
  oitr_state_t state_next;

  logic det_flag;

  // ************************************************************
  // Read decode
  // ************************************************************
  function automatic logic [DATA_W-1:0] read_mux(
    input logic [ADDR_W-1:0] addr,
    input oitr_state_t       s
  );
    case (addr)
      ADDR_IMB_TRIM: read_mux = s.imbalance_trim;
      ADDR_OVERRANGE_DETECT_ENABLE:   read_mux = s.overrange_enable_ctrl;
      ADDR_OVERRANGE_HOLD_CTRL: read_mux = s.overrange_hold_ctrl;
      ADDR_OVERRANGE_THRESHOLD_LEVEL:   read_mux = s.overrange_threshold_level;
      default:       read_mux = UNMAPPED_RDATA;
    endcase
  endfunction

  // ************************************************************
  // Detector
  // ************************************************************
  // Detector sees live register values so a change takes effect at once
  oitr_ovr_detect #(
    .LATENCY (OVR_LATENCY)
  ) u_detect (
    .clk       (clk),
    .arst_n    (arst_n),
    .sample    (sample),
    .enable    (state_reg.overrange_enable_ctrl[EN_BIT]),
    .hold_code (state_reg.overrange_hold_ctrl[HOLD_LSB +: HOLD_W]),
    .thresh    (state_reg.overrange_threshold_level),
    .ovr_flag  (det_flag)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Pins pass two flops; only the second stage is looked at
  always_comb begin
    logic              rise;
    logic              fall;
    logic [BCNT_W-1:0] cnt_inc;
    logic [ADDR_W-1:0] addr;
    logic              overrange_detect_enable;
    logic [DATA_W-1:0] rdata;
    rise       = 1'b0;
    rdata      = '0;
    fall       = 1'b0;
    cnt_inc    = '0;
    addr       = '0;
    overrange_detect_enable     = state_reg.overrange_enable_ctrl[EN_BIT];
    state_next = state_reg;

    state_next.sync1     = spi_pins;
    state_next.sync2     = state_reg.sync1;
    state_next.sclk_prev = state_reg.sync2.sclk;
    state_next.ovr_out   = det_flag;

    rise    = state_reg.sync2.sclk && !state_reg.sclk_prev;
    fall    = !state_reg.sync2.sclk && state_reg.sclk_prev;
    cnt_inc = state_reg.bitcnt + 5'h1;
    addr    = state_reg.shreg[ADDR_W-1:0];

    case (state_reg.st)
      ST_IDLE: begin
        state_next.bitcnt   = '0;
        state_next.rd_phase = 1'b0;
        // Idle SDO carries the indicator only when enabled
        state_next.sdo    = overrange_detect_enable & det_flag;
        state_next.sdo_oe = overrange_detect_enable;
        if (!state_reg.sync2.cs_n) begin
          state_next.st = ST_SHIFT;
          state_next.sdo    = 1'b0;
          state_next.sdo_oe = 1'b0;
        end
      end

      ST_SHIFT: begin
        if (state_reg.sync2.cs_n) begin
          // Short frames are dropped without any write
          state_next.st     = ST_IDLE;
          state_next.sdo_oe = 1'b0;
          state_next.sdo    = 1'b0;
        end else if (rise && state_reg.bitcnt < BCNT_FRAME) begin
          state_next.shreg  = {state_reg.shreg[FRAME_BITS-2:0],
                               state_reg.sync2.sdi};
          state_next.bitcnt = cnt_inc;
          if (cnt_inc == BCNT_HDR && state_reg.shreg[HDR_BITS-2]) begin
            // Header done on a read: present the MSB at once
            addr = {state_reg.shreg[ADDR_W-2:0], state_reg.sync2.sdi};
            rdata               = read_mux(addr, state_reg);
            state_next.outsh    = rdata;
            state_next.sdo      = rdata[DATA_W-1];
            state_next.sdo_oe   = 1'b1;
            state_next.rd_phase = 1'b1;
          end
          if (cnt_inc == BCNT_FRAME && !state_reg.shreg[FRAME_BITS-2]) begin
            // Write commits on the last rising edge
            addr = state_reg.shreg[DATA_W+ADDR_W-2:DATA_W-1];
            case (addr)
              ADDR_IMB_TRIM:
                state_next.imbalance_trim =
                  {state_reg.shreg[DATA_W-2:0], state_reg.sync2.sdi};
              ADDR_OVERRANGE_DETECT_ENABLE:
                state_next.overrange_enable_ctrl =
                  {state_reg.shreg[DATA_W-2:0], state_reg.sync2.sdi};
              ADDR_OVERRANGE_HOLD_CTRL:
                state_next.overrange_hold_ctrl =
                  {state_reg.shreg[DATA_W-2:0], state_reg.sync2.sdi};
              ADDR_OVERRANGE_THRESHOLD_LEVEL:
                state_next.overrange_threshold_level =
                  {state_reg.shreg[DATA_W-2:0], state_reg.sync2.sdi};
              default: begin
                state_next.imbalance_trim = state_reg.imbalance_trim;
              end
            endcase
          end
        end else if (fall && state_reg.rd_phase &&
                     state_reg.bitcnt > BCNT_HDR &&
                     state_reg.bitcnt < BCNT_FRAME) begin
          // Next read bit goes out on the falling edge
          state_next.outsh = {state_reg.outsh[DATA_W-2:0], 1'b0};
          state_next.sdo   = state_reg.outsh[DATA_W-2];
        end
      end

      default: begin
        state_next.st = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Chip select idles high, so its synchroniser resets to one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg                           <= '0;
      state_reg.sync1                     <= 3'b001;
      state_reg.sync2                     <= 3'b001;
      state_reg.st                        <= ST_IDLE;
      state_reg.imbalance_trim            <= RST_IMB_TRIM;
      state_reg.overrange_enable_ctrl     <= RST_OVERRANGE_DETECT_ENABLE;
      state_reg.overrange_hold_ctrl       <= RST_OVERRANGE_HOLD_CTRL;
      state_reg.overrange_threshold_level <= RST_OVERRANGE_THRESHOLD_LEVEL;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Reserved bits are stored as written; trim fields decode here
  assign amplitude_trim_code =
    state_reg.imbalance_trim[AMP_LSB +: AMP_W];
  assign phase_trim_code =
    state_reg.imbalance_trim[PH_LSB +: PH_W];
  assign overrange_indicator = state_reg.ovr_out;
  assign sdo                 = state_reg.sdo;
  assign sdo_oe              = state_reg.sdo_oe;

endmodule

//--- pkg/oitr_pkg.sv
// Constants, types and helpers shared by the trim and over-range block
// Notes on behaviour
// - Enable bit gates detection and pin output
// - Flag over-range when input reaches the threshold, or full scale for code 0
// - Hold codes add 0, 3, 7, 15 cycles
// - Hold extension starts when input falls back
// - Hold counted in sampling clock periods
// - Indicator follows sample after fixed latency
// - Amplitude trim code bits 6:4, reset 000
// - Phase trim code bits 3:0, reset 0000
// - Hold, enable, threshold registers reset to zero
package oitr_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int                 ADDR_W          = 15;
  localparam int                 DATA_W          = 8;
  localparam logic [ADDR_W-1:0]  ADDR_IMB_TRIM   = 15'h0014;
  localparam logic [ADDR_W-1:0]  ADDR_OVERRANGE_DETECT_ENABLE     = 15'h003a;
  localparam logic [ADDR_W-1:0]  ADDR_OVERRANGE_HOLD_CTRL   = 15'h003b;
  localparam logic [ADDR_W-1:0]  ADDR_OVERRANGE_THRESHOLD_LEVEL     = 15'h003c;
  localparam logic [DATA_W-1:0]  RST_IMB_TRIM    = 8'h00;
  localparam logic [DATA_W-1:0]  RST_OVERRANGE_DETECT_ENABLE      = 8'h00;
  localparam logic [DATA_W-1:0]  RST_OVERRANGE_HOLD_CTRL    = 8'h00;
  localparam logic [DATA_W-1:0]  RST_OVERRANGE_THRESHOLD_LEVEL      = 8'h00;
  localparam logic [DATA_W-1:0]  UNMAPPED_RDATA  = 8'h00;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int AMP_LSB  = 4;
  localparam int AMP_W    = 3;
  localparam int PH_LSB   = 0;
  localparam int PH_W     = 4;
  localparam int EN_BIT   = 0;
  localparam int HOLD_LSB = 0;
  localparam int HOLD_W   = 2;

  // ************************************************************
  // Serial frame: read flag, 15-bit address, 8-bit data
  // ************************************************************
  localparam int             FRAME_BITS = 24;
  localparam int             HDR_BITS   = 16;
  localparam int             BCNT_W     = 5;
  localparam logic [BCNT_W-1:0] BCNT_HDR   = 5'h10;
  localparam logic [BCNT_W-1:0] BCNT_FRAME = 5'h18;

  // ************************************************************
  // Over-range detection
  // ************************************************************
  localparam int                  SAMPLE_W     = 16;
  localparam int                  HCNT_W       = 4;
  localparam int                  TH_SHIFT     = 7;
  localparam logic signed [16:0]  FULL_POS     = 17'sh07fff;
  localparam logic signed [16:0]  FULL_NEG     = -17'sh08000;
  localparam int                  LATENCY_DEF  = 4;
  localparam logic [HCNT_W-1:0]   HOLD_EXT_00  = 4'h0;
  localparam logic [HCNT_W-1:0]   HOLD_EXT_01  = 4'h3;
  localparam logic [HCNT_W-1:0]   HOLD_EXT_10  = 4'h7;
  localparam logic [HCNT_W-1:0]   HOLD_EXT_11  = 4'hf;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic cs_n;
  } oitr_spi_pins_t;

  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] data;
  } oitr_sample_t;

  // Hold code to extra sampling periods
  function automatic logic [HCNT_W-1:0] oitr_hold_cycles(
    input logic [HOLD_W-1:0] code
  );
    case (code)
      2'h0:    oitr_hold_cycles = HOLD_EXT_00;
      2'h1:    oitr_hold_cycles = HOLD_EXT_01;
      2'h2:    oitr_hold_cycles = HOLD_EXT_10;
      default: oitr_hold_cycles = HOLD_EXT_11;
    endcase
  endfunction

endpackage

//--- rtl/oitr_ovr_detect.sv
// Over-range detector with pipeline latency and hold extension
`timescale 1ns/1ps
module oitr_ovr_detect
  import oitr_pkg::*;
#(
  parameter int LATENCY = LATENCY_DEF
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire oitr_sample_t      sample,
  input  wire logic              enable,
  input  wire logic [HOLD_W-1:0] hold_code,
  input  wire logic [DATA_W-1:0] thresh,
  output logic                   ovr_flag
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (LATENCY < 1 || LATENCY > 64) begin : g_bad_latency
    $error("oitr_ovr_detect: LATENCY must be 1 to 64");
  end

  typedef struct packed {
    logic [LATENCY-1:0] pipe;
    logic [HCNT_W-1:0]  hcnt;
    logic               flag;
  } oitr_det_state_t;

  oitr_det_state_t state_reg;
  oitr_det_state_t state_next;

  // Sample at or beyond either limit; code 0 means the rail codes
  function automatic logic beyond(
    input logic signed [SAMPLE_W-1:0] s,
    input logic [DATA_W-1:0]          th
  );
    logic signed [16:0] hi;
    logic signed [16:0] lo;
    // Placed by slice so no tool can shift in a narrow self width
    hi = '0;
    hi[TH_SHIFT +: DATA_W] = th;
    if (th == 8'h00) begin
      hi = FULL_POS;
    end
    lo = (th == 8'h00) ? FULL_NEG : -hi;
    beyond = (17'(s) >= hi) || (17'(s) <= lo);
  endfunction

  // Pipeline and hold counter advance on sample strobes only
  always_comb begin
    logic over_now;
    logic over_late;
    over_now   = 1'b0;
    over_late  = 1'b0;
    state_next = state_reg;
    if (!enable) begin
      state_next = '0;
    end else if (sample.valid) begin
      over_now  = beyond(sample.data, thresh);
      over_late = state_reg.pipe[LATENCY-1];
      // Oldest stage drops off the top; also legal for a one-stage pipe
      state_next.pipe = LATENCY'({state_reg.pipe, over_now});
      if (over_late) begin
        state_next.hcnt = oitr_hold_cycles(hold_code);
        state_next.flag = 1'b1;
      end else if (state_reg.hcnt != '0) begin
        state_next.hcnt = state_reg.hcnt - 4'h1;
        state_next.flag = 1'b1;
      end else begin
        state_next.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ovr_flag = state_reg.flag;

endmodule

//--- tb/oitr_host.sv
// Host model driving the serial configuration port
`timescale 1ns/1ps
module oitr_host
  import oitr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sdo,
  output oitr_spi_pins_t spi_pins
);
  initial spi_pins = '{sclk: 1'b0, sdi: 1'b1, cs_n: 1'b1};

  // Waits counted on falling edges, host moves off the sampling edge
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One whole frame; phases of 6 clk keep sclk well under 25 MHz
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr,
                      input logic [DATA_W-1:0] wd,
                      output logic [DATA_W-1:0] rdat);
    logic [FRAME_BITS-1:0] fr;
    fr = {rd, addr, wd};
    rdat = '0;
    @(negedge clk);
    spi_pins.cs_n = 1'b0;
    wait_clk(6);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      spi_pins.sdi = fr[i];
      wait_clk(6);
      spi_pins.sclk = 1'b1;
      wait_clk(6);
      if (i < DATA_W) rdat[i] = sdo; // Bit stands until this fall
      spi_pins.sclk = 1'b0;
    end
    wait_clk(12);
    spi_pins.cs_n = 1'b1;
    spi_pins.sdi = ~spi_pins.sdi; // Released line shows no stale value
    wait_clk(8);
  endtask
endmodule

//--- tb/oitr_regs_properties.sv
// Port checks for the trim and over-range register block
`timescale 1ns/1ps
module oitr_regs_properties
  import oitr_pkg::*;
#(
  parameter int OVR_LATENCY = LATENCY_DEF
) (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire oitr_spi_pins_t     spi_pins,
  input wire oitr_sample_t       sample,
  input wire logic               sdo,
  input wire logic               sdo_oe,
  input wire logic [AMP_W-1:0]   amplitude_trim_code,
  input wire logic [PH_W-1:0]    phase_trim_code,
  input wire logic               overrange_indicator
);
  logic [3:0] idle_cnt;
  logic [1:0] since_vld;

  // Saturating counts: cycles deselected, cycles since a strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_cnt <= 4'h0;
      since_vld <= 2'h3;
    end else begin
      idle_cnt <= !spi_pins.cs_n ? 4'h0 :
                  (idle_cnt == 4'hf) ? idle_cnt : idle_cnt + 4'h1;
      since_vld <= sample.valid ? 2'h0 :
                   (since_vld == 2'h3) ? since_vld : since_vld + 2'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_FIRST_IDLE: assert property ($rose(arst_n) |->
    !sdo_oe && !sdo && amplitude_trim_code == 3'h0 && phase_trim_code == 4'h0)
    else $error("outputs not cleared by reset");
  AST_TRIM_IN_FRAME: assert property (
    $changed({amplitude_trim_code, phase_trim_code}) |-> !$past(spi_pins.cs_n, 4))
    else $error("trim code moved outside a frame");
  AST_IND_RISE_STROBE: assert property (
    $rose(overrange_indicator) |-> since_vld != 2'h3)
    else $error("indicator rose without a sample strobe");
  AST_IND_FALL_STROBE: assert property (
    $fell(overrange_indicator) |-> since_vld != 2'h3 || idle_cnt < 4'h8)
    else $error("indicator fell without a sample strobe");
  AST_SDO_FOLLOWS: assert property (
    idle_cnt == 4'hf && sdo_oe |-> sdo == overrange_indicator)
    else $error("sdo does not carry the indicator");
  AST_SDO_IDLE_LOW: assert property (
    idle_cnt == 4'hf && !sdo_oe |-> !sdo)
    else $error("sdo not low while undriven");
  AST_OE_IDLE_STABLE: assert property (
    idle_cnt == 4'hf |-> $stable(sdo_oe))
    else $error("sdo enable moved between frames");
  AST_IND_NEEDS_EN: assert property (
    overrange_indicator && idle_cnt == 4'hf |-> sdo_oe)
    else $error("indicator high while detection off");

  // Main scenarios reached
  COV_IND_RISE: cover property ($rose(overrange_indicator));
  COV_IND_FALL: cover property ($fell(overrange_indicator));
  COV_READ: cover property (!spi_pins.cs_n && sdo_oe);
endmodule

bind oitr_regs oitr_regs_properties #(.OVR_LATENCY(OVR_LATENCY))
  u_oitr_regs_properties (.clk(clk), .arst_n(arst_n),
  .spi_pins(spi_pins), .sample(sample), .sdo(sdo), .sdo_oe(sdo_oe),
  .amplitude_trim_code(amplitude_trim_code),
  .phase_trim_code(phase_trim_code),
  .overrange_indicator(overrange_indicator));

//--- tb/oitr_regs_bench.sv
// Self-checking bench for the trim and over-range register block
`timescale 1ns/1ps
module oitr_regs_bench;
  import oitr_pkg::*;
  localparam int LAT = 3;
  typedef struct packed {
    logic        en;
    logic [1:0]  hold;
    logic [7:0]  th;
    logic [15:0] d;
    logic        ov;
    logic [1:0]  stride;
  } oitr_row_t;
  logic           clk;
  logic           arst_n;
  oitr_spi_pins_t spi_pins;
  oitr_sample_t   sample;
  logic           sdo;
  logic           sdo_oe;
  logic [2:0]     amp_code;
  logic [3:0]     ph_code;
  logic           ovr_ind;
  logic [7:0]     rd;
  int             n_fail = 0;
  int             n_compared = 0;
  int             cnt;
  int             first;
  int             ext[4] = '{0, 3, 7, 15};
  oitr_row_t      rows[10] = '{
    '{1, 0, 8'h00, 16'h7fff, 1, 1}, '{1, 0, 8'h00, 16'h7ffe, 0, 1},
    '{1, 1, 8'h00, 16'h8000, 1, 1}, '{1, 2, 8'h01, 16'h0080, 1, 1},
    '{1, 3, 8'h01, 16'h007f, 0, 1}, '{1, 3, 8'h01, 16'hff80, 1, 1},
    '{1, 2, 8'h80, 16'h4000, 1, 1}, '{1, 1, 8'h80, 16'hc001, 0, 1},
    '{0, 3, 8'h00, 16'h7fff, 0, 1}, '{1, 3, 8'h00, 16'h7fff, 1, 2}};

  oitr_host u_oitr_host (.clk(clk), .sdo(sdo), .spi_pins(spi_pins));
  oitr_regs #(.OVR_LATENCY(LAT)) u_oitr_regs (.clk(clk),
    .arst_n(arst_n), .spi_pins(spi_pins), .sample(sample), .sdo(sdo),
    .sdo_oe(sdo_oe), .amplitude_trim_code(amp_code),
    .phase_trim_code(ph_code), .overrange_indicator(ovr_ind));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_oitr_host.xfer(1'b0, a, d, unused);
  endtask

  // Strobes every stride clk, the row's test sample at k=4
  task automatic run_row(input oitr_row_t r);
    cnt = 0;
    first = -1;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      if (ovr_ind === 1'b1) begin
        cnt++;
        if (first < 0) first = k;
      end
      sample.valid = (k < 80) && (k % r.stride == 0);
      sample.data = (k == 4) ? r.d : 16'h0000;
    end
    sample.valid = 1'b0;
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // *****
  // Main sequence
  // *****
  initial begin
    arst_n = 1'b0;
    sample = '0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      wr(ADDR_OVERRANGE_DETECT_ENABLE, {7'h00, rows[i].en});
      wr(ADDR_OVERRANGE_HOLD_CTRL, {6'h00, rows[i].hold});
      wr(ADDR_OVERRANGE_THRESHOLD_LEVEL, rows[i].th);
      run_row(rows[i]);
      chk(16'(cnt), 16'((rows[i].en && rows[i].ov) ?
          (1 + ext[rows[i].hold]) * rows[i].stride : 0));
      // Over sample strobed at k=4, LAT strobes on, one flop, seen a step on
      if (rows[i].en && rows[i].ov)
        chk(16'(first), 16'(4 + LAT * rows[i].stride + 2));
    end
    arst_n = 1'b0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int a = 8'h3a; a <= 8'h3c; a++) begin
      u_oitr_host.xfer(1'b1, 15'(a), 8'h00, rd);
      chk({8'h00, rd}, 16'h0000);
    end
    chk({9'h0, amp_code, ph_code}, 16'h0000);
    wr(ADDR_IMB_TRIM, 8'h79);
    chk({9'h0, amp_code, ph_code}, 16'h0079);
    u_oitr_host.xfer(1'b1, ADDR_IMB_TRIM, 8'h00, rd);
    chk({8'h00, rd}, 16'h0079);
    wr(ADDR_OVERRANGE_HOLD_CTRL, 8'h03);
    u_oitr_host.xfer(1'b1, ADDR_OVERRANGE_HOLD_CTRL, 8'h00, rd);
    chk({8'h00, rd}, 16'h0003);
    wr(15'h0020, 8'hff);
    u_oitr_host.xfer(1'b1, 15'h0020, 8'h00, rd);
    chk({8'h00, rd}, 16'h0000);
    print_verdict();
  end
endmodule
